// [rtl/ofdm_receiver_phr_control.sv]
`timescale 1ns/1ns
module ofdm_receiver_phr_control (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // modem status
    input wire logic rx_enable_i,
    input wire logic preamble_found_i,
    input wire logic sync_done_i,
    input wire logic rx_phr_valid_i,
    input wire logic [21:0] rx_phr_i,
    input wire logic [7:0] rx_hcs_i,
    input wire logic frame_end_i,
    input wire logic symbol_strobe_i,
    input wire logic [7:0] symbol_power_i,
    input wire logic [7:0] measured_power_i,
    input wire logic [10:0] tx_length_i,
    // events and control to the modem
    output logic agc_hold_irq_o,
    output logic frame_start_irq_o,
    output logic restart_o,
    output logic agc_freeze_o,
    output logic narrow_search_span_o,
    output logic [2:0] header_scheme_o,
    output ofdm_rx_pkg::rx_state_e rx_state_o,
    output logic [21:0] tx_phr_o,
    // configuration to the frontends
    output logic [1:0] phy_type_select_o,
    output logic [1:0] bandwidth_option_o,
    output logic interleaving_attribute_o,
    output logic [1:0] tx_scrambler_seed_o,
    output logic [2:0] preamble_detect_threshold_o,
    output logic spurious_compensation_enable_o,
    output logic [3:0] rx_sample_rate_code_o,
    output logic [2:0] rx_digital_cutoff_o,
    output logic [3:0] rx_analog_bandwidth_o,
    output logic rx_if_shift_o,
    output logic [1:0] agc_average_period_o,
    output logic agc_speed_select_o,
    output logic [2:0] agc_target_level_o,
    output logic [1:0] energy_time_base_o,
    output logic [5:0] energy_duration_factor_o
);
    import ofdm_rx_pkg::*;

    function automatic logic [2:0] lowest_scheme(input logic [1:0] opt);
        unique case (opt)
            2'h0: return 3'h0;
            2'h1: return 3'h0;
            2'h2: return 3'h1;
            2'h3: return 3'h2;
        endcase
    endfunction : lowest_scheme

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        return adr == ofs;
    endfunction : hit

    phr_if phr ();

    rx_state_e st_q;
    rx_state_e st_d;
    logic ack_q;
    logic [31:0] dat_q;
    logic [7:0] cfg_q;
    logic [7:0] txh_q;
    logic [7:0] rxh_q;
    logic [7:0] sw_q;
    logic [7:0] len_hi_q;
    logic [7:0] len_lo_q;
    logic [7:0] edv_q;
    logic [7:0] edd_q;
    logic [7:0] agc_q;
    logic [2:0] tgt_q;
    logic [7:0] fe_q;
    logic [7:0] bw_q;
    logic [1:0] phy_q;
    logic [1:0] ev_q;
    logic freeze_q;
    logic agc_hold_q;
    logic frame_start_q;
    logic restart_q;
    logic [7:0] prev_pwr_q;
    logic [21:0] tx_phr_q;
    logic req;
    logic wr;
    logic [7:0] wbyte;
    logic rise_w;
    logic detect_w;
    logic hdr_ok_w;
    logic hdr_bad_w;
    logic restart_w;
    logic [7:0] rdata;

    assign req = wb_cyc_i && wb_stb_i;
    assign wr = req && wb_we_i && ack_q && wb_sel_i[0];
    assign wbyte = wb_dat_i[7:0];

    phr_header_check u_check (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i (ce_i),
        .phr (phr.checker_mp)
    );

    assign phr.hdr = rx_phr_i;
    assign phr.hcs = rx_hcs_i;
    assign phr.valid_in = rx_phr_valid_i && (st_q == ST_HEADER);

    // power rise between consecutive symbols
    assign rise_w = symbol_strobe_i &&
        ({1'b0, symbol_power_i} > ({1'b0, prev_pwr_q} + POWER_RISE_DB));
    assign detect_w = ce_i && (st_q == ST_SEARCH) && preamble_found_i;
    assign hdr_ok_w = ce_i && (st_q == ST_HEADER) && phr.valid && phr.crc_ok &&
        (phr.length != 11'h000);
    assign hdr_bad_w = ce_i && (st_q == ST_HEADER) && phr.valid && !hdr_ok_w;
    assign restart_w = ce_i && sw_q[SW_RXO_BIT] && rise_w &&
        (st_q inside {ST_SYNC, ST_HEADER, ST_PAYLOAD});

    always_comb begin
        st_d = st_q;
        if (!rx_enable_i) begin
            st_d = ST_IDLE;
        end else if (restart_w) begin
            st_d = ST_SEARCH;
        end else begin
            unique case (st_q)
                ST_IDLE: st_d = ST_SEARCH;
                ST_SEARCH: if (preamble_found_i) st_d = ST_SYNC;
                ST_SYNC: if (sync_done_i) st_d = ST_HEADER;
                ST_HEADER: begin
                    if (hdr_ok_w) begin
                        st_d = ST_PAYLOAD;
                    end else if (hdr_bad_w) begin
                        st_d = ST_SEARCH;
                    end
                end
                ST_PAYLOAD: if (frame_end_i) st_d = ST_SEARCH;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= ST_IDLE;
        end else if (ce_i) begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_pwr_q <= 8'h00;
        end else if (ce_i && symbol_strobe_i) begin
            prev_pwr_q <= symbol_power_i;
        end
    end

    // agc hold pulse and freeze flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            agc_hold_q <= 1'b0;
            freeze_q <= 1'b0;
        end else if (ce_i) begin
            agc_hold_q <= detect_w && rx_enable_i;
            if (detect_w && rx_enable_i) begin
                freeze_q <= 1'b1;
            end else if (st_d inside {ST_IDLE, ST_SEARCH}) begin
                freeze_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frame_start_q <= 1'b0;
            restart_q <= 1'b0;
        end else if (ce_i) begin
            frame_start_q <= hdr_ok_w && rx_enable_i && !restart_w;
            restart_q <= restart_w && rx_enable_i;
        end
    end

    // header status captured at frame start
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            len_hi_q <= CONFIG_BYTE_RST;
            len_lo_q <= CONFIG_BYTE_RST;
            edv_q <= CONFIG_BYTE_RST;
            rxh_q <= CONFIG_BYTE_RST;
            cfg_q <= CONFIG_BYTE_RST;
        end else if (ce_i) begin
            if (hdr_ok_w && rx_enable_i && !restart_w) begin
                len_hi_q <= {5'h00, phr.length[10:8]};
                len_lo_q <= phr.length[7:0];
                edv_q <= measured_power_i;
                rxh_q[7:4] <= phr.rsv;
                rxh_q[2:0] <= phr.scheme;
                cfg_q[CFG_SSRX_LSB +: 2] <= phr.seed;
            end
            if (wr && hit(wb_adr_i, RX_PHY_HEADER_STATUS_OFS)) begin
                rxh_q[RXH_SPC_BIT] <= wbyte[RXH_SPC_BIT];
            end
            if (wr && hit(wb_adr_i, OFDM_CONFIG_OFS)) begin
                cfg_q[5:0] <= wbyte[5:0];
            end
        end
    end

    // software configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phy_q <= 2'h0;
            txh_q <= TX_PHY_HEADER_CONFIG_RST;
            sw_q <= {PREAMBLE_THRESHOLD_RST, 5'h00};
            edd_q <= CONFIG_BYTE_RST;
            agc_q <= CONFIG_BYTE_RST;
            tgt_q <= AGC_TARGET_RST;
            fe_q <= CONFIG_BYTE_RST;
            bw_q <= CONFIG_BYTE_RST;
        end else if (ce_i && wr) begin
            if (hit(wb_adr_i, PHY_CTRL_OFS)) phy_q <= wbyte[1:0];
            if (hit(wb_adr_i, TX_PHY_HEADER_CONFIG_OFS)) begin
                txh_q <= wbyte & TXH_WRITE_MASK;
            end
            if (hit(wb_adr_i, OFDM_SWITCHES_OFS)) sw_q <= {wbyte[7:4], 4'h0};
            if (hit(wb_adr_i, ENERGY_DURATION_OFS)) edd_q <= wbyte;
            if (hit(wb_adr_i, AGC_CONFIG_OFS)) agc_q <= {5'h00, wbyte[2:0]};
            if (hit(wb_adr_i, AGC_TARGET_OFS)) tgt_q <= wbyte[2:0];
            if (hit(wb_adr_i, RX_FRONTEND_OFS)) fe_q <= {1'b0, wbyte[6:0]};
            if (hit(wb_adr_i, RX_BANDWIDTH_OFS)) bw_q <= {3'h0, wbyte[4:0]};
        end
    end

    // sticky events, set wins over a write-one clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ev_q <= 2'h0;
        end else if (ce_i) begin
            ev_q <= (ev_q & ~((wr && hit(wb_adr_i, EVENT_STATUS_OFS)) ? wbyte[1:0] : 2'h0))
                | {frame_start_q, agc_hold_q};
        end
    end

    // transmit header composition
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_phr_q <= 22'h00_0000;
        end else if (ce_i) begin
            tx_phr_q[PHR_RATE_LSB +: 5] <= {2'b00, txh_q[TXH_MCS_LSB +: 3]};
            tx_phr_q[PHR_RB5_POS] <= txh_q[TXH_RB5_BIT];
            tx_phr_q[PHR_LEN_MSB:PHR_LEN_LSB] <= tx_length_i;
            tx_phr_q[PHR_RB17_POS] <= txh_q[TXH_RB17_BIT];
            tx_phr_q[PHR_RB18_POS] <= txh_q[TXH_RB18_BIT];
            tx_phr_q[PHR_SEED_LSB +: 2] <= cfg_q[CFG_SSTX_LSB +: 2];
            tx_phr_q[PHR_RB21_POS] <= txh_q[TXH_RB21_BIT];
        end
    end

    always_comb begin
        rdata = 8'h00;
        unique case (wb_adr_i)
            PHY_CTRL_OFS: rdata = {6'h00, phy_q};
            OFDM_CONFIG_OFS: rdata = cfg_q;
            TX_PHY_HEADER_CONFIG_OFS: rdata = txh_q;
            RX_PHY_HEADER_STATUS_OFS: rdata = rxh_q;
            OFDM_SWITCHES_OFS: rdata = sw_q;
            RX_LENGTH_HIGH_OFS: rdata = len_hi_q;
            RX_LENGTH_LOW_OFS: rdata = len_lo_q;
            ENERGY_VALUE_OFS: rdata = edv_q;
            ENERGY_DURATION_OFS: rdata = edd_q;
            AGC_CONFIG_OFS: rdata = {3'h0, freeze_q, agc_q[3:0]};
            AGC_TARGET_OFS: rdata = {5'h00, tgt_q};
            RX_FRONTEND_OFS: rdata = fe_q;
            RX_BANDWIDTH_OFS: rdata = bw_q;
            EVENT_STATUS_OFS: rdata = {6'h00, ev_q};
            default: rdata = 8'h00;
        endcase
    end

    // one wait state: ack the cycle after the request appears
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_q <= req && !ack_q;
            if (req && !ack_q) begin
                dat_q <= {24'h00_0000, rdata};
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign agc_hold_irq_o = agc_hold_q;
    assign frame_start_irq_o = frame_start_q;
    assign restart_o = restart_q;
    assign agc_freeze_o = freeze_q;
    assign narrow_search_span_o = cfg_q[CFG_LFO_BIT];
    assign header_scheme_o = lowest_scheme(cfg_q[CFG_OPT_LSB +: 2]);
    assign rx_state_o = st_q;
    assign tx_phr_o = tx_phr_q;
    assign phy_type_select_o = phy_q;
    assign bandwidth_option_o = cfg_q[CFG_OPT_LSB +: 2];
    assign interleaving_attribute_o = cfg_q[CFG_POI_BIT];
    assign tx_scrambler_seed_o = cfg_q[CFG_SSTX_LSB +: 2];
    assign preamble_detect_threshold_o = sw_q[SW_PDT_LSB +: 3];
    assign spurious_compensation_enable_o = rxh_q[RXH_SPC_BIT];
    assign rx_sample_rate_code_o = fe_q[3:0];
    assign rx_digital_cutoff_o = fe_q[6:4];
    assign rx_analog_bandwidth_o = bw_q[3:0];
    assign rx_if_shift_o = bw_q[4];
    assign agc_average_period_o = agc_q[2:1];
    assign agc_speed_select_o = agc_q[0];
    assign agc_target_level_o = tgt_q;
    assign energy_time_base_o = edd_q[1:0];
    assign energy_duration_factor_o = edd_q[7:2];

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_frame_start_gate: assert property ($rose(frame_start_q) |-> $past(hdr_ok_w))
        else $error("frame start without a good header");
    a_length_capture: assert property ($rose(frame_start_q) |->
        ({len_hi_q[2:0], len_lo_q} == $past(phr.length)) && (edv_q == $past(measured_power_i)))
        else $error("received length or energy not captured");
    a_scheme_capture: assert property ($rose(frame_start_q) |->
        (rxh_q[2:0] == $past(phr.scheme)) && (rxh_q[7:4] == $past(phr.rsv)))
        else $error("received scheme or reserved bits not captured");
    a_freeze_detect: assert property (detect_w && rx_enable_i |=> agc_hold_q && freeze_q)
        else $error("preamble detection did not hold agc");
    a_tx_rate_field: assert property (ce_i |=>
        tx_phr_q[4:0] == {2'b00, $past(txh_q[2:0])})
        else $error("transmit rate field wrong");
    a_tx_reserved: assert property (ce_i |=> tx_phr_q[PHR_RB21_POS] == $past(txh_q[7])
        && tx_phr_q[PHR_RB5_POS] == $past(txh_q[4]))
        else $error("transmit reserved bit not passed through");
    a_ro_bit_zero: assert property (wb_ack_o && !wb_we_i &&
        wb_adr_i == TX_PHY_HEADER_CONFIG_OFS |-> !wb_dat_o[TXH_RO_BIT])
        else $error("read-only header bit reads as one");
    a_restart_rise: assert property (restart_w && rx_enable_i |=>
        st_q == ST_SEARCH && restart_q && !freeze_q)
        else $error("override did not restart the search");
    a_header_scheme: assert property (st_q == ST_HEADER |->
        header_scheme_o == lowest_scheme(bandwidth_option_o))
        else $error("header scheme not lowest for option");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    c_frame_start: cover property (st_q == ST_HEADER ##1 frame_start_q);
    c_restart: cover property (st_q == ST_PAYLOAD && restart_w);
    c_crc_fail: cover property (hdr_bad_w ##1 st_q == ST_SEARCH);

endmodule : ofdm_receiver_phr_control

// [rtl/ofdm_rx_pkg.sv]
package ofdm_rx_pkg;

    // register byte offsets, one aligned word each
    localparam logic [7:0] PHY_CTRL_OFS = 8'h00;
    localparam logic [7:0] OFDM_CONFIG_OFS = 8'h04;
    localparam logic [7:0] TX_PHY_HEADER_CONFIG_OFS = 8'h08;
    localparam logic [7:0] RX_PHY_HEADER_STATUS_OFS = 8'h0C;
    localparam logic [7:0] OFDM_SWITCHES_OFS = 8'h10;
    localparam logic [7:0] RX_LENGTH_HIGH_OFS = 8'h14;
    localparam logic [7:0] RX_LENGTH_LOW_OFS = 8'h18;
    localparam logic [7:0] ENERGY_VALUE_OFS = 8'h1C;
    localparam logic [7:0] ENERGY_DURATION_OFS = 8'h20;
    localparam logic [7:0] AGC_CONFIG_OFS = 8'h24;
    localparam logic [7:0] AGC_TARGET_OFS = 8'h28;
    localparam logic [7:0] RX_FRONTEND_OFS = 8'h2C;
    localparam logic [7:0] RX_BANDWIDTH_OFS = 8'h30;
    localparam logic [7:0] EVENT_STATUS_OFS = 8'h34;

    // reset values
    localparam logic [7:0] TX_PHY_HEADER_CONFIG_RST = 8'h00;
    localparam logic [2:0] AGC_TARGET_RST = 3'h3;
    localparam logic [2:0] PREAMBLE_THRESHOLD_RST = 3'h0;
    localparam logic [7:0] CONFIG_BYTE_RST = 8'h00;

    // transmit header configuration fields
    localparam int TXH_RB21_BIT = 7;
    localparam int TXH_RB18_BIT = 6;
    localparam int TXH_RB17_BIT = 5;
    localparam int TXH_RB5_BIT = 4;
    localparam int TXH_RO_BIT = 3;
    localparam int TXH_MCS_LSB = 0;
    localparam logic [7:0] TXH_WRITE_MASK = 8'hF7;

    // received header status fields
    localparam int RXH_SPC_BIT = 3;

    // ofdm configuration fields
    localparam int CFG_SSRX_LSB = 6;
    localparam int CFG_SSTX_LSB = 4;
    localparam int CFG_LFO_BIT = 3;
    localparam int CFG_POI_BIT = 2;
    localparam int CFG_OPT_LSB = 0;

    // switches fields
    localparam int SW_PDT_LSB = 5;
    localparam int SW_RXO_BIT = 4;

    // event status bits, write one to clear
    localparam int EV_AGC_HOLD_BIT = 0;
    localparam int EV_FRAME_START_BIT = 1;

    // header bit positions
    localparam int PHR_WIDTH = 22;
    localparam int PHR_RATE_LSB = 0;
    localparam int PHR_RB5_POS = 5;
    localparam int PHR_LEN_LSB = 6;
    localparam int PHR_LEN_MSB = 16;
    localparam int PHR_RB17_POS = 17;
    localparam int PHR_RB18_POS = 18;
    localparam int PHR_SEED_LSB = 19;
    localparam int PHR_RB21_POS = 21;
    localparam logic [7:0] HCS_POLY = 8'h07;

    // restart threshold on a symbol-to-symbol power rise, in dB
    localparam logic [8:0] POWER_RISE_DB = 9'h00C;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SEARCH,
        ST_SYNC,
        ST_HEADER,
        ST_PAYLOAD
    } rx_state_e;

endpackage : ofdm_rx_pkg

// [rtl/phr_if.sv]
`timescale 1ns/1ns
interface phr_if;
    logic [21:0] hdr;
    logic [7:0] hcs;
    logic valid_in;
    logic valid;
    logic crc_ok;
    logic [10:0] length;
    logic [2:0] scheme;
    logic [1:0] seed;
    logic [3:0] rsv;

    modport checker_mp (input hdr, hcs, valid_in,
        output valid, crc_ok, length, scheme, seed, rsv);
    modport ctrl_mp (output hdr, hcs, valid_in,
        input valid, crc_ok, length, scheme, seed, rsv);
endinterface : phr_if

// [rtl/phr_header_check.sv]
`timescale 1ns/1ns
module phr_header_check
    import ofdm_rx_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    phr_if.checker_mp phr
);

    // serial crc-8 over the header, first bit first
    function automatic logic [7:0] hcs_calc(input logic [21:0] h);
        logic [7:0] c;
        logic fb;
        c = 8'h00;
        fb = 1'b0;
        for (int i = PHR_WIDTH - 1; i >= 0; i--) begin
            fb = c[7] ^ h[i];
            c = {c[6:0], 1'b0};
            if (fb) begin
                c = c ^ HCS_POLY;
            end
        end
        return c;
    endfunction : hcs_calc

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phr.valid <= 1'b0;
            phr.crc_ok <= 1'b0;
        end else if (ce_i) begin
            phr.valid <= phr.valid_in;
            phr.crc_ok <= phr.valid_in && (hcs_calc(phr.hdr) == phr.hcs);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phr.length <= 11'h000;
            phr.scheme <= 3'h0;
            phr.seed <= 2'h0;
            phr.rsv <= 4'h0;
        end else if (ce_i && phr.valid_in) begin
            phr.length <= phr.hdr[PHR_LEN_MSB:PHR_LEN_LSB];
            phr.scheme <= phr.hdr[PHR_RATE_LSB +: 3];
            phr.seed <= phr.hdr[PHR_SEED_LSB +: 2];
            phr.rsv <= {phr.hdr[PHR_RB21_POS], phr.hdr[PHR_RB18_POS],
                        phr.hdr[PHR_RB17_POS], phr.hdr[PHR_RB5_POS]};
        end
    end

endmodule : phr_header_check

// [tb/ofdm_tx_partner.sv]
`timescale 1ns/1ns
module ofdm_tx_partner (
    input wire logic clk_i,
    output logic preamble_o,
    output logic sync_o,
    output logic phr_valid_o,
    output logic [21:0] phr_o,
    output logic [7:0] hcs_o,
    output logic strobe_o,
    output logic [7:0] power_o
);
    initial begin
        {preamble_o, sync_o, phr_valid_o, strobe_o} = '0;
        phr_o = '0;
        hcs_o = '0;
        power_o = '0;
    end
    function automatic logic [7:0] crc8(input logic [21:0] h);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 21; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction : crc8
    // detect, sync, then header; bad flips one check bit
    task automatic frame(input logic [21:0] h, input logic bad);
        @(posedge clk_i) preamble_o <= 1'b1;
        @(posedge clk_i) preamble_o <= 1'b0;
        sync_o <= 1'b1;
        @(posedge clk_i) sync_o <= 1'b0;
        phr_o <= h;
        hcs_o <= crc8(h) ^ {7'h00, bad};
        phr_valid_o <= 1'b1;
        @(posedge clk_i) phr_valid_o <= 1'b0;
        // released lines carry no stale header
        phr_o <= ~h;
        hcs_o <= ~hcs_o;
    endtask : frame
    task automatic power(input logic [7:0] p);
        @(posedge clk_i) strobe_o <= 1'b1;
        power_o <= p;
        @(posedge clk_i) strobe_o <= 1'b0;
        power_o <= ~p;
    endtask : power
endmodule : ofdm_tx_partner

// [tb/ofdm_receiver_phr_control_bench.sv]
`timescale 1ns/1ns
module ofdm_receiver_phr_control_bench;
    import ofdm_rx_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, rx_en = 0, ce = 1, fend = 0;
    logic [7:0] adr = '0, mpow = '0, hcs, spow;
    logic [31:0] dat = '0, rdat;
    logic [10:0] tlen = '0;
    logic pf, sd, pv, ss, ack, fs, ah, rs, nss;
    logic [21:0] phr, tphr;
    logic [2:0] hsch;
    rx_state_e st;
    logic [7:0] q[$];
    int failures = 0, n_tests = 0, cycles = 0, n_fs = 0, n_ah = 0, n_rs = 0;

    ofdm_tx_partner i_ofdm_tx_partner (.clk_i, .preamble_o(pf), .sync_o(sd), .phr_valid_o(pv),
        .phr_o(phr), .hcs_o(hcs), .strobe_o(ss), .power_o(spow));
    ofdm_receiver_phr_control i_ofdm_receiver_phr_control (.clk_i, .rst_i, .ce_i(ce),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .rx_enable_i(rx_en),
        .preamble_found_i(pf), .sync_done_i(sd), .rx_phr_valid_i(pv), .rx_phr_i(phr),
        .rx_hcs_i(hcs), .frame_end_i(fend), .symbol_strobe_i(ss), .symbol_power_i(spow),
        .measured_power_i(mpow), .tx_length_i(tlen), .agc_hold_irq_o(ah),
        .frame_start_irq_o(fs), .restart_o(rs), .agc_freeze_o(), .narrow_search_span_o(nss),
        .header_scheme_o(hsch), .rx_state_o(st), .tx_phr_o(tphr), .phy_type_select_o(),
        .bandwidth_option_o(), .interleaving_attribute_o(), .tx_scrambler_seed_o(),
        .preamble_detect_threshold_o(), .spurious_compensation_enable_o(),
        .rx_sample_rate_code_o(), .rx_digital_cutoff_o(), .rx_analog_bandwidth_o(),
        .rx_if_shift_o(), .agc_average_period_o(), .agc_speed_select_o(),
        .agc_target_level_o(), .energy_time_base_o(), .energy_duration_factor_o());

    initial forever #10 clk_i = ~clk_i;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out
    // one classic cycle; a read notes its expected byte first
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        if (!w) q.push_back(d);
        @(posedge clk_i);
        cyc <= 1'b1;
        adr <= a;
        we <= w;
        dat <= {24'h0, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        cyc <= 1'b0;
        we <= 1'b0;
    endtask : bus

    always @(posedge clk_i) begin
        cycles++;
        if (ack === 1'b1 && !we && q.size() > 0) chk("read", {24'h0, q.pop_front()}, rdat);
        if (fs === 1'b1) n_fs++;
        if (ah === 1'b1) n_ah++;
        if (rs === 1'b1) n_rs++;
        if (cycles == 20000) begin
            failures++;
            close_out();
        end
    end

    initial begin : main
        logic [7:0] b, cfg, fe, bw;
        logic spc;
        logic [10:0] len;
        logic [31:0] r;
        logic [21:0] h;
        void'($urandom(32'hb8034b6d));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(TX_PHY_HEADER_CONFIG_OFS, 1'b0, 8'h00);
        bus(AGC_TARGET_OFS, 1'b0, 8'h03);
        bus(8'h3C, 1'b1, 8'hFF);
        bus(8'h3C, 1'b0, 8'h00);
        for (int o = 0; o < 4; o++) begin
            b = 8'($urandom);
            r = $urandom;
            cfg = {2'b00, b[1:0], b[3:2], 2'(o)};
            len = 11'($urandom) | 11'h001;
            h = {r[0], r[2:1], r[3], r[4], len, r[5], 2'b00, 3'(r[8:6] % 7)};
            rx_en <= 1'b0;
            tlen <= 11'($urandom);
            mpow <= 8'($urandom);
            fe = {1'b0, 3'((cfg[3] ? 16'h1224 : 16'h1324) >> (4 * o)), (o < 2) ? 4'h3 : 4'h6};
            bw = {3'h0, 1'((cfg[3] ? 4'b1011 : 4'b0111) >> o),
                4'((cfg[3] ? 16'h2479 : 16'h357A) >> (4 * o))};
            spc = (o != 3);
            bus(OFDM_CONFIG_OFS, 1'b1, cfg);
            bus(RX_FRONTEND_OFS, 1'b1, fe);
            bus(RX_BANDWIDTH_OFS, 1'b1, bw);
            bus(AGC_CONFIG_OFS, 1'b1, 8'h00);
            bus(AGC_TARGET_OFS, 1'b1, spc ? 8'h00 : 8'h03);
            bus(ENERGY_DURATION_OFS, 1'b1, {6'd30, 2'd2});
            bus(RX_PHY_HEADER_STATUS_OFS, 1'b1, {4'h0, spc, 3'h0});
            bus(RX_FRONTEND_OFS, 1'b0, fe);
            bus(RX_BANDWIDTH_OFS, 1'b0, bw);
            bus(ENERGY_DURATION_OFS, 1'b0, 8'h7A);
            bus(AGC_CONFIG_OFS, 1'b0, 8'h00);
            bus(AGC_TARGET_OFS, 1'b0, spc ? 8'h00 : 8'h03);
            bus(TX_PHY_HEADER_CONFIG_OFS, 1'b1, b);
            bus(OFDM_SWITCHES_OFS, 1'b1, {3'(16'h3455 >> (4 * o)), 5'h10});
            bus(TX_PHY_HEADER_CONFIG_OFS, 1'b0, b & 8'hF7);
            @(posedge clk_i);
            chk("scheme", (o < 2) ? 0 : o - 1, hsch);
            chk("span", cfg[3], nss);
            chk("txhdr", {b[7], cfg[5:4], b[6], b[5], tlen, b[4], 2'b00, b[2:0]}, tphr);
            rx_en <= 1'b1;
            repeat (2) @(posedge clk_i);
            i_ofdm_tx_partner.frame(h, 1'b0);
            repeat (4) @(posedge clk_i);
            chk("frames", o + 1, n_fs);
            mpow <= ~mpow;
            bus(RX_PHY_HEADER_STATUS_OFS, 1'b0, {r[0], r[3], r[4], r[5], spc, h[2:0]});
            bus(OFDM_CONFIG_OFS, 1'b0, {r[2:1], cfg[5:0]});
            bus(RX_LENGTH_HIGH_OFS, 1'b0, {5'h00, len[10:8]});
            bus(RX_LENGTH_LOW_OFS, 1'b0, len[7:0]);
            bus(ENERGY_VALUE_OFS, 1'b0, ~mpow);
            i_ofdm_tx_partner.power(8'd10);
            i_ofdm_tx_partner.power(8'd22);
            i_ofdm_tx_partner.power(8'd35);
            repeat (2) @(posedge clk_i);
            chk("restarts", o + 1, n_rs);
            h[16:6] = o[0] ? 11'h000 : len;
            i_ofdm_tx_partner.frame(h, !o[0]);
            repeat (4) @(posedge clk_i);
            chk("frames", o + 1, n_fs);
            chk("state", ST_SEARCH, st);
        end
        chk("holds", 8, n_ah);
        close_out();
    end
endmodule : ofdm_receiver_phr_control_bench
